// file: dlc_label_change.sv
// modem-side handler for label change requests, responses and acknowledges
// What this block and the headend do
// R1 - headend keeps old list until response
// R2 - headend delays acknowledge after response
// R3 - request widens loss detection to union
// R4 - filter discards outside union while pending
// R5 - acknowledge: wait, then contract to new
// R6 - headend reverts list on missing response
// R7 - no acknowledge: log, restore loss detection
// R8 - headend applies skew reduction first
// R9 - headend applies skew increase after responses
// R10 - apply wait time before responding
// R11 - no forwarding before label configured
// R12 - headend: request, response, then acknowledge
// R13 - headend recovers failed multicast change
// R14 - headend adds label with encodings
// R15 - addresses only: mask treated zero
// R16 - mask only: bind mask interfaces
// R17 - both: bind union of sets
// R18 - neither: keep binding unchanged
// R19 - addresses only: replace list, keep mask
// R20 - mask only: replace mask, keep list
// R21 - both: update both, bind union
// R22 - delete ignores encodings, clears state
// R23 - invalid request rejected with error code
// R24 - acknowledge enables loss detection on every configured non-multicast label
// R25 - track transaction, ignore mismatches, count retries
`timescale 1ns/1ps
`default_nettype none
module dlc_label_change #(
  parameter int                           RETRY_CYC = dlc_pkg::ACK_RETRY_CYC,
  parameter logic [dlc_pkg::RETRY_W-1:0]  RETRY_MAX = dlc_pkg::RETRY_LIMIT_DEF
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // change requests from the message parser
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire dlc_pkg::dlc_req_t            req_data,
  // change acknowledges
  input  wire logic                         ack_valid,
  input  wire logic [dlc_pkg::TXN_W-1:0]    ack_txn_id,
  // change responses toward the transmitter
  output logic                              rsp_valid,
  input  wire logic                         rsp_ready,
  output dlc_pkg::dlc_rsp_t                 rsp_data,
  // frame filter query
  input  wire logic [dlc_pkg::LBL_W-1:0]    frm_label,
  input  wire logic [dlc_pkg::NUM_CHAN-1:0] frm_chan,
  output logic                              frm_accept,
  output logic [dlc_pkg::NUM_IF-1:0]        frm_ifs,
  // per-label loss detection status and one block-wide acknowledge failure flag
  output logic [dlc_pkg::NUM_LABELS-1:0]    loss_det_en,
  output logic                              ack_error
);

  localparam int NL = dlc_pkg::NUM_LABELS;
  localparam int NC = dlc_pkg::NUM_CHAN;
  localparam int NI = dlc_pkg::NUM_IF;
  localparam int NA = dlc_pkg::NUM_ADDR;
  localparam int RW = $clog2(RETRY_CYC + 1);
  localparam logic [RW-1:0] RETRY_LOAD = RW'(RETRY_CYC - 1);

  typedef enum logic [1:0] {
    DLC_IDLE,
    DLC_RESPOND,
    DLC_AWAIT_ACK,
    DLC_SETTLE
  } dlc_state_t;

  // per-label state
  logic [NC-1:0]          cur_list_q [NL];
  logic [NC-1:0]          new_list_q [NL];
  logic [NC-1:0]          filt_list_q[NL];
  logic [dlc_pkg::WAIT_W-1:0] wait_q [NL];
  logic [NI-1:0]          mask_q     [NL];
  logic [NA-1:0]          addr_v_q   [NL];
  logic [NA*NI-1:0]       addr_if_q  [NL];
  logic [NL-1:0]          is_mc_q;
  logic [NL-1:0]          cfg_q;
  logic [NL-1:0]          lde_q;

  // transaction state
  dlc_state_t                 st_q;
  dlc_pkg::dlc_req_t          cur_q;
  logic [dlc_pkg::RETRY_W-1:0] retry_q;
  logic [RW-1:0]              tmr_q;
  logic                       ack_err_q;
  dlc_pkg::dlc_rsp_t          rsp_word;
  logic                       rsp_push;
  logic                       buf_ready;
  logic                       ack_hit;
  logic                       retry_out;
  logic                       settle_done;
  logic                       settle_busy;
  logic [dlc_pkg::ERR_W-1:0]  chk_err;
  logic [NI-1:0]              addr_union;
  logic [NI-1:0]              bind_ifs [NL];
  logic [dlc_pkg::ERR_W-1:0]  chk_err_q;

  // requests are taken only while idle and only one transaction stands
  assign req_ready   = (st_q == DLC_IDLE);
  // R25 match acknowledge id
  assign ack_hit     = ack_valid && (st_q == DLC_AWAIT_ACK) && (ack_txn_id == cur_q.txn_id);
  assign retry_out   = (st_q == DLC_AWAIT_ACK) && (tmr_q == '0) && (retry_q == RETRY_MAX);
  assign loss_det_en = lde_q;
  assign ack_error   = ack_err_q;

  // R23 validity check on the request
  always_comb begin
    chk_err = dlc_pkg::ERR_NONE;
    if (req_data.op == dlc_pkg::DLC_OP_MCAST_SET) begin
      if (!cfg_q[req_data.label] && !req_data.has_addr && !req_data.has_mask)
        chk_err = dlc_pkg::ERR_NO_ENC;
      else if (cfg_q[req_data.label] && !is_mc_q[req_data.label])
        chk_err = dlc_pkg::ERR_NOT_MC;
    end else if (req_data.op == dlc_pkg::DLC_OP_MCAST_DEL) begin
      if (!cfg_q[req_data.label] || !is_mc_q[req_data.label])
        chk_err = dlc_pkg::ERR_BAD_LABEL;
    end else if (cfg_q[req_data.label] && is_mc_q[req_data.label]) begin
      chk_err = dlc_pkg::ERR_NOT_MC;
    end
  end

  // transaction sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q    <= DLC_IDLE;
      cur_q   <= '0;
      retry_q <= '0;
      tmr_q   <= '0;
    end else begin
      unique case (st_q)
        DLC_IDLE: begin
          if (req_valid) begin
            cur_q <= req_data;
            st_q  <= DLC_RESPOND;
          end
        end
        DLC_RESPOND: begin
          if (buf_ready) begin
            retry_q <= '0;
            tmr_q   <= RETRY_LOAD;
            if (rsp_word.reject || cur_q.op != dlc_pkg::DLC_OP_CHANLIST)
              st_q <= DLC_IDLE;
            else
              st_q <= DLC_AWAIT_ACK;
          end
        end
        DLC_AWAIT_ACK: begin
          // R25 retry counting
          if (ack_hit) begin
            st_q <= DLC_SETTLE;
          end else if (retry_out) begin
            st_q <= DLC_IDLE;
          end else if (tmr_q == '0) begin
            retry_q <= retry_q + 1'b1;
            tmr_q   <= RETRY_LOAD;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        DLC_SETTLE: begin
          if (settle_done) st_q <= DLC_IDLE;
        end
      endcase
    end
  end

  // R23 rejecting response carries an error code
  always_comb begin
    rsp_word.txn_id   = cur_q.txn_id;
    rsp_word.err_code = chk_err_q;
    rsp_word.reject   = (chk_err_q != dlc_pkg::ERR_NONE);
  end
  // request check captured at the taken edge, request bus may move after
  always_ff @(posedge ref_clk) begin
    if (sys_rst) chk_err_q <= dlc_pkg::ERR_NONE;
    else if (st_q == DLC_IDLE && req_valid) chk_err_q <= chk_err;
  end
  // R10 response pushed only after the label update has landed
  assign rsp_push = (st_q == DLC_RESPOND);

  // R5 resequencing wait before contraction
  dlc_wait_timer #(.WIDTH(dlc_pkg::WAIT_W)) u_wait (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (ack_hit),
    .load    (wait_q[cur_q.label]),
    .busy    (settle_busy),
    .done    (settle_done)
  );

  // acknowledge failure log, sticky until reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) ack_err_q <= 1'b0;
    // R7 log missing acknowledge
    else if (retry_out) ack_err_q <= 1'b1;
  end

  // per-label configuration updates
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lbl
      localparam int LBL_W = dlc_pkg::LBL_W;
      logic sel;
      assign sel = (st_q == DLC_IDLE) && req_valid && (chk_err == dlc_pkg::ERR_NONE)
                   && (req_data.label == LBL_W'(g));

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          cur_list_q[g]  <= '0;
          new_list_q[g]  <= '0;
          filt_list_q[g] <= '0;
          wait_q[g]      <= '0;
          mask_q[g]      <= '0;
          addr_v_q[g]    <= '0;
          addr_if_q[g]   <= '0;
          is_mc_q[g]     <= 1'b0;
          cfg_q[g]       <= 1'b0;
          lde_q[g]       <= 1'b0;
        end else if (sel) begin
          unique case (req_data.op)
            dlc_pkg::DLC_OP_CHANLIST: begin
              // R3 widen loss detection to the union
              new_list_q[g]  <= req_data.chan_list;
              lde_q[g]       <= 1'b1;
              // R4 filter keeps the union while pending
              filt_list_q[g] <= cur_list_q[g] | req_data.chan_list;
              cfg_q[g]       <= 1'b1;
            end
            dlc_pkg::DLC_OP_WAITTIME: begin
              // R10 new wait time applied
              wait_q[g] <= req_data.wait_time;
              cfg_q[g]  <= 1'b1;
            end
            dlc_pkg::DLC_OP_MCAST_SET: begin
              is_mc_q[g] <= 1'b1;
              cfg_q[g]   <= 1'b1;
              if (!cfg_q[g]) begin
                // R15 addresses only: mask zero
                mask_q[g]    <= req_data.has_mask ? req_data.if_mask : '0;
                addr_v_q[g]  <= req_data.has_addr ? req_data.addr_valid : '0;
                addr_if_q[g] <= req_data.addr_ifs;
              end else begin
                // R19 R20 R21 replace only what is carried; R18 neither keeps all
                if (req_data.has_mask) mask_q[g] <= req_data.if_mask;
                if (req_data.has_addr) begin
                  addr_v_q[g]  <= req_data.addr_valid;
                  addr_if_q[g] <= req_data.addr_ifs;
                end
              end
            end
            dlc_pkg::DLC_OP_MCAST_DEL: begin
              // R22 delete clears all forwarding state
              is_mc_q[g]   <= 1'b0;
              cfg_q[g]     <= 1'b0;
              mask_q[g]    <= '0;
              addr_v_q[g]  <= '0;
              addr_if_q[g] <= '0;
            end
          endcase
        end else if (settle_done && cur_q.label == LBL_W'(g)) begin
          // R5 contract to the new list
          cur_list_q[g]  <= new_list_q[g];
          filt_list_q[g] <= new_list_q[g];
          // R5 loss detection stays on over the new list
          lde_q[g]       <= 1'b1;
        end else if (ack_hit && cfg_q[g] && !is_mc_q[g]) begin
          // R24 acknowledge enables loss detection on every configured non-multicast label
          lde_q[g] <= 1'b1;
        end else if (retry_out && cur_q.label == LBL_W'(g)) begin
          // R7 restore loss detection, keep union filter
          lde_q[g] <= 1'b1;
        end
      end

      // R17 union of address and mask interfaces
      always_comb begin
        bind_ifs[g] = mask_q[g];
        for (int a = 0; a < NA; a++) begin
          if (addr_v_q[g][a]) bind_ifs[g] = bind_ifs[g] | addr_if_q[g][a*NI +: NI];
        end
      end
    end
  endgenerate

  // frame filter; R11 unconfigured labels never forward
  always_comb begin
    frm_accept = cfg_q[frm_label] &&
                 (is_mc_q[frm_label] || ((frm_chan & filt_list_q[frm_label]) != '0));
    // R16 forward only to bound interfaces
    frm_ifs = is_mc_q[frm_label] ? bind_ifs[frm_label] : '0;
  end

  // response buffer so a stalled transmitter loses no response
  dlc_rsp_buf #(.WIDTH($bits(dlc_pkg::dlc_rsp_t))) u_rsp (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (rsp_push),
    .in_ready  (buf_ready),
    .in_data   (rsp_word),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );

  // a taken request moves the sequencer to the respond state on the next cycle
  sequence s_req_taken;
    req_valid && req_ready;
  endsequence
  a_rsp_after_req: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_req_taken |=> (st_q == DLC_RESPOND))  // R10
    else $error("request not moved to respond");
  a_ack_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ack_valid && ack_txn_id != cur_q.txn_id && st_q == DLC_AWAIT_ACK) |=> (st_q != DLC_SETTLE))  // R25
    else $error("mismatched acknowledge accepted");
  a_ack_fail_log: assert property (@(posedge ref_clk) disable iff (sys_rst)
    retry_out |=> ack_error && (st_q == DLC_IDLE))  // R7
    else $error("missing acknowledge not logged");
  a_settle_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q == DLC_SETTLE) |-> settle_busy || settle_done)  // R5
    else $error("settle without wait timer");
  a_unconf_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cfg_q[frm_label] |-> !frm_accept)  // R11
    else $error("unconfigured label forwarded");
  a_reject_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rsp_push && rsp_word.reject) |-> (rsp_word.err_code != dlc_pkg::ERR_NONE))  // R23
    else $error("reject without error code");
  a_union_filter: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_req_taken and chk_err == dlc_pkg::ERR_NONE and req_data.op == dlc_pkg::DLC_OP_CHANLIST)
    |=> (filt_list_q[cur_q.label] & cur_q.chan_list) == cur_q.chan_list)  // R4
    else $error("filter not widened");
  a_del_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_req_taken and chk_err == dlc_pkg::ERR_NONE and req_data.op == dlc_pkg::DLC_OP_MCAST_DEL)
    |=> !cfg_q[cur_q.label] && mask_q[cur_q.label] == '0)  // R22
    else $error("delete left state");

endmodule : dlc_label_change
`default_nettype wire

// file: dlc_pkg.sv
// package for the downstream label change handler: constants, types, structs
package dlc_pkg;

  localparam int NUM_LABELS  = 4;
  localparam int NUM_CHAN    = 8;
  localparam int NUM_IF      = 8;
  localparam int NUM_ADDR    = 4;
  localparam int TXN_W       = 16;
  localparam int WAIT_W      = 16;
  localparam int RETRY_W     = 4;
  localparam int LBL_W       = 2;
  localparam int ADDR_IDX_W  = 2;
  localparam int ERR_W       = 8;

  // retry interval of the acknowledge timer, in microseconds and in cycles
  localparam int CLK_MHZ        = 50;
  localparam int ACK_RETRY_US   = 10;
  localparam int ACK_RETRY_CYC  = ACK_RETRY_US * CLK_MHZ;
  localparam logic [RETRY_W-1:0] RETRY_LIMIT_DEF = 4'h3;

  // error codes returned in a rejecting response
  localparam logic [ERR_W-1:0] ERR_NONE      = 8'h00;
  localparam logic [ERR_W-1:0] ERR_BAD_LABEL = 8'h01;
  localparam logic [ERR_W-1:0] ERR_NO_ENC    = 8'h02;
  localparam logic [ERR_W-1:0] ERR_NOT_MC    = 8'h03;

  // request kind carried by a change request
  typedef enum logic [1:0] {
    DLC_OP_CHANLIST,
    DLC_OP_WAITTIME,
    DLC_OP_MCAST_SET,
    DLC_OP_MCAST_DEL
  } dlc_op_t;

  // decoded change request
  typedef struct packed {
    logic [TXN_W-1:0]       txn_id;
    dlc_op_t                op;
    logic [LBL_W-1:0]       label;
    logic [NUM_CHAN-1:0]    chan_list;
    logic [WAIT_W-1:0]      wait_time;
    logic                   has_addr;
    logic [NUM_ADDR-1:0]    addr_valid;
    logic [NUM_ADDR*NUM_IF-1:0] addr_ifs;
    logic                   has_mask;
    logic [NUM_IF-1:0]      if_mask;
  } dlc_req_t;

  // change response word
  typedef struct packed {
    logic [TXN_W-1:0] txn_id;
    logic             reject;
    logic [ERR_W-1:0] err_code;
  } dlc_rsp_t;

endpackage : dlc_pkg

// file: dlc_rsp_buf.sv
// two-entry response buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dlc_rsp_buf #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem_q [2];
  logic             rd_q;
  logic             wr_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  // handshakes; full buffer stalls the writer
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop)  rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : dlc_rsp_buf
`default_nettype wire

// file: dlc_wait_timer.sv
// countdown timer for the resequencing wait before contracting a channel list
`timescale 1ns/1ps
`default_nettype none
module dlc_wait_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_q;
  logic             run_q;

  assign busy = run_q;

  // a zero load expires on the next edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= load;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule : dlc_wait_timer
`default_nettype wire

// file: dlc_headend_model.sv
// headend partner model: issues change requests, drains responses, sends acknowledges
`timescale 1ns/1ps
`default_nettype none
module dlc_headend_model (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  // request path
  output logic                           req_valid,
  input  wire logic                      req_ready,
  output dlc_pkg::dlc_req_t              req_data,
  // acknowledge path
  output logic                           ack_valid,
  output logic [dlc_pkg::TXN_W-1:0]      ack_txn_id,
  // response path
  input  wire logic                      rsp_valid,
  output logic                           rsp_ready,
  input  wire dlc_pkg::dlc_rsp_t         rsp_data
);
  logic              stall;
  dlc_pkg::dlc_rsp_t rsp_q[$];
  dlc_pkg::dlc_rsp_t last_rsp;
  int                fails;

  // idle outputs at time zero
  initial begin
    req_valid  = 1'b0;
    req_data   = '0;
    ack_valid  = 1'b0;
    ack_txn_id = '0;
    stall      = 1'b0;
    fails      = 0;
  end

  // a stalled headend simply stops draining responses
  assign rsp_ready = !stall;

  // collect responses in arrival order
  always @(posedge ref_clk) begin
    if (!sys_rst && rsp_valid && rsp_ready) rsp_q.push_back(rsp_data);
  end

  // hold the request until taken, then scramble the released bus
  task automatic send_req(input dlc_pkg::dlc_req_t r);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_data  <= r;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    if (n >= 200) fails++;
    req_valid <= 1'b0;
    req_data  <= ~r;
  endtask : send_req

  // bounded wait for the next drained response
  task automatic wait_rsp();
    int n;
    n = 0;
    while (rsp_q.size() == 0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (rsp_q.size() == 0) fails++;
    else last_rsp = rsp_q.pop_front();
  endtask : wait_rsp

  task automatic send_ack(input logic [15:0] id, input int gap);
    repeat (gap + 1) @(posedge ref_clk);
    ack_valid  <= 1'b1;
    ack_txn_id <= id;
    @(posedge ref_clk);
    ack_valid  <= 1'b0;
    ack_txn_id <= ~id;
  endtask : send_ack

  // request, response, then acknowledge with same id
  task automatic transact(input dlc_pkg::dlc_req_t r, input logic do_ack, input int gap);
    send_req(r);
    wait_rsp();
    // no response: withhold ack, caller recovers
    if (do_ack && fails == 0) send_ack(r.txn_id, gap);
  endtask : transact
endmodule : dlc_headend_model
`default_nettype wire

// file: dlc_label_change_tb.sv
// self-checking testbench for the downstream label change handler
`timescale 1ns/1ps
`default_nettype none
module dlc_label_change_tb;
  localparam int RCYC = 8;  // shortened retry interval keeps the run brief

  logic                           ref_clk;
  logic                           sys_rst;
  logic                           req_valid;
  logic                           req_ready;
  dlc_pkg::dlc_req_t              req_data;
  logic                           ack_valid;
  logic [dlc_pkg::TXN_W-1:0]      ack_txn_id;
  logic                           rsp_valid;
  logic                           rsp_ready;
  dlc_pkg::dlc_rsp_t              rsp_data;
  logic [dlc_pkg::LBL_W-1:0]      frm_label;
  logic [dlc_pkg::NUM_CHAN-1:0]   frm_chan;
  logic                           frm_accept;
  logic [dlc_pkg::NUM_IF-1:0]     frm_ifs;
  logic [dlc_pkg::NUM_LABELS-1:0] loss_det_en;
  logic                           ack_error;
  int                             err_total;
  int                             total_checks;

  // device under test with a short retry interval
  dlc_label_change #(.RETRY_CYC(RCYC), .RETRY_MAX(dlc_pkg::RETRY_LIMIT_DEF)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .ack_valid(ack_valid), .ack_txn_id(ack_txn_id),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .frm_label(frm_label), .frm_chan(frm_chan), .frm_accept(frm_accept),
    .frm_ifs(frm_ifs), .loss_det_en(loss_det_en), .ack_error(ack_error));

  // headend partner
  dlc_headend_model u_hem (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .ack_valid(ack_valid), .ack_txn_id(ack_txn_id),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    check("partner waits", u_hem.fails, 0);
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // multicast request builder
  function automatic dlc_pkg::dlc_req_t mc(input logic [15:0] t, input logic [1:0] l,
      input logic ha, input logic [3:0] av, input logic [31:0] ai, input logic hm,
      input logic [7:0] m);
    mc = '{t, dlc_pkg::DLC_OP_MCAST_SET, l, 8'h00, 16'h0000, ha, av, ai, hm, m};
  endfunction : mc

  // resequencing request builder
  function automatic dlc_pkg::dlc_req_t cl(input logic [15:0] t, input dlc_pkg::dlc_op_t op,
      input logic [7:0] ch, input logic [15:0] wt);
    cl = '{t, op, 2'h0, ch, wt, 1'b0, 4'h0, 32'h0000_0000, 1'b0, 8'h00};
  endfunction : cl

  // filter query, read once the combinational answer has settled
  task automatic probe(input logic [1:0] l, input logic [7:0] c);
    @(posedge ref_clk);
    frm_label <= l;
    frm_chan  <= c;
    @(posedge ref_clk);
    #1;
  endtask : probe

  task automatic mc_step(input dlc_pkg::dlc_req_t r, input logic [7:0] exp_ifs);
    u_hem.transact(r, 1'b1, 2);
    check("mc reject", u_hem.last_rsp.reject, 1'b0);
    check("mc txn", u_hem.last_rsp.txn_id, r.txn_id);
    probe(r.label, 8'h01);
    check("mc ifs", frm_ifs, exp_ifs);
  endtask : mc_step

  task automatic t_reset();
    check("idle ready", req_ready, 1'b1);
    check("idle rsp", rsp_valid, 1'b0);
    check("idle loss", loss_det_en, 4'h0);
    check("idle err", ack_error, 1'b0);
    probe(2'h1, 8'h01);
    check("unknown label", frm_accept, 1'b0);
    $display("done reset");
  endtask : t_reset

  task automatic t_mc_add();
    u_hem.transact(mc(16'h0001, 2'h2, 1'b0, 4'h0, 32'h0, 1'b0, 8'h00), 1'b0, 0);
    check("bad reject", u_hem.last_rsp.reject, 1'b1);
    check("bad code", u_hem.last_rsp.err_code, dlc_pkg::ERR_NO_ENC);
    mc_step(mc(16'h0002, 2'h1, 1'b0, 4'h0, 32'h0, 1'b1, 8'h0f), 8'h0f);
    mc_step(mc(16'h0003, 2'h2, 1'b1, 4'h3, 32'h2010, 1'b0, 8'hff), 8'h30);
    mc_step(mc(16'h0004, 2'h3, 1'b1, 4'h1, 32'h0001, 1'b1, 8'h80), 8'h81);
    $display("done multicast add");
  endtask : t_mc_add

  task automatic t_mc_change();
    dlc_pkg::dlc_req_t r;
    mc_step(mc(16'h0010, 2'h3, 1'b0, 4'h0, 32'h0, 1'b0, 8'h00), 8'h81);
    mc_step(mc(16'h0011, 2'h3, 1'b1, 4'h1, 32'h0002, 1'b0, 8'h00), 8'h82);
    mc_step(mc(16'h0012, 2'h3, 1'b0, 4'h0, 32'h0, 1'b1, 8'h40), 8'h42);
    mc_step(mc(16'h0013, 2'h3, 1'b1, 4'h1, 32'h0004, 1'b1, 8'h08), 8'h0c);
    r = mc(16'h0014, 2'h3, 1'b1, 4'hf, 32'hffff_ffff, 1'b1, 8'hff);
    r.op = dlc_pkg::DLC_OP_MCAST_DEL;
    mc_step(r, 8'h00);
    check("deleted accept", frm_accept, 1'b0);
    r.txn_id = 16'h0015;
    u_hem.transact(r, 1'b0, 0);
    check("gone reject", u_hem.last_rsp.err_code, dlc_pkg::ERR_BAD_LABEL);
    $display("done multicast change");
  endtask : t_mc_change

  // receiver stalls while two responses queue up, then drains in order
  task automatic t_stall();
    u_hem.stall <= 1'b1;
    u_hem.send_req(mc(16'h0020, 2'h1, 1'b0, 4'h0, 32'h0, 1'b0, 8'h00));
    u_hem.send_req(mc(16'h0021, 2'h1, 1'b0, 4'h0, 32'h0, 1'b0, 8'h00));
    repeat (6) @(posedge ref_clk);
    #1;
    check("held valid", rsp_valid, 1'b1);
    check("none drained", u_hem.rsp_q.size(), 0);
    u_hem.stall <= 1'b0;
    u_hem.wait_rsp();
    check("first txn", u_hem.last_rsp.txn_id, 16'h0020);
    u_hem.wait_rsp();
    check("second txn", u_hem.last_rsp.txn_id, 16'h0021);
    $display("done stall");
  endtask : t_stall

  task automatic t_chanlist();
    // wait time sent with no skew change in flight
    u_hem.transact(cl(16'h0030, dlc_pkg::DLC_OP_WAITTIME, 8'h00, 16'h0008), 1'b0, 0);
    check("wait reject", u_hem.last_rsp.reject, 1'b0);
    u_hem.transact(cl(16'h0031, dlc_pkg::DLC_OP_CHANLIST, 8'h03, 16'h0008), 1'b1, 2);
    repeat (20) @(posedge ref_clk);
    u_hem.transact(cl(16'h0032, dlc_pkg::DLC_OP_CHANLIST, 8'h0c, 16'h0008), 1'b0, 0);
    check("list reject", u_hem.last_rsp.reject, 1'b0);
    probe(2'h0, 8'h01);
    check("old chan", frm_accept, 1'b1);
    probe(2'h0, 8'h04);
    check("new chan", frm_accept, 1'b1);
    probe(2'h0, 8'h10);
    check("outside union", frm_accept, 1'b0);
    check("pending busy", req_ready, 1'b0);
    u_hem.send_ack(16'h0032, 2);
    probe(2'h0, 8'h01);
    check("old during wait", frm_accept, 1'b1);
    repeat (12) @(posedge ref_clk);
    probe(2'h0, 8'h01);
    check("old contracted", frm_accept, 1'b0);
    probe(2'h0, 8'h04);
    check("new kept", frm_accept, 1'b1);
    check("loss on", loss_det_en[0], 1'b1);
    check("back idle", req_ready, 1'b1);
    $display("done channel list");
  endtask : t_chanlist

  task automatic t_ack_timeout();
    u_hem.transact(cl(16'h0040, dlc_pkg::DLC_OP_CHANLIST, 8'h30, 16'h0008), 1'b0, 0);
    u_hem.send_ack(16'h0041, 0);
    #1;
    check("stray ack busy", req_ready, 1'b0);
    check("no early err", ack_error, 1'b0);
    repeat (RCYC * 4 + 20) @(posedge ref_clk);
    #1;
    check("ack err", ack_error, 1'b1);
    check("idle again", req_ready, 1'b1);
    check("loss restored", loss_det_en[0], 1'b1);
    u_hem.transact(mc(16'h0042, 2'h0, 1'b0, 4'h0, 32'h0, 1'b1, 8'h01), 1'b0, 0);
    check("type reject", u_hem.last_rsp.err_code, dlc_pkg::ERR_NOT_MC);
    $display("done ack timeout");
  endtask : t_ack_timeout

  // main sequence: reset held ten cycles, then every scenario
  initial begin
    ref_clk      = 1'b0;
    sys_rst      = 1'b1;
    frm_label    = 2'h0;
    frm_chan     = 8'h00;
    err_total    = 0;
    total_checks = 0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_mc_add();
    t_mc_change();
    t_stall();
    t_chanlist();
    t_ack_timeout();
    complete_run();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    complete_run();
  end
endmodule : dlc_label_change_tb
`default_nettype wire
